// ==== core/register_window_remap.sv ====
/*
  Register-window remap: holds the window-select register and maps
  register-direct CPU accesses onto the physical register space.
  Assumes the CPU core presents one access per cycle on a single clock
  and that memory returns read data from phys_addr a cycle later.
*/
// Overview of operation
// - Window sits at 00E0H, 00C0H or 0080H for 32, 64 or 128 bytes.
// - Physical address is segment base plus offset from window base.
// - CAN SFR segments from 1E00H: codes 70-77, 38-3B, 1C-1D.
// - Peripheral SFR segments from 1F00H: codes 78-7F, 3C-3F, 1E-1F.
// - 1FE0H-1FFFH never windowed; reads give FFH, writes dropped.
// - Code 1FH still reaches 1F80H-1FDFH; only the top range is blocked.
// - Code 4AH maps 0140H to window, so 014BH appears at 00EBH.
// - Code 3EH maps 1F80H to window, so 1F8CH appears at 00CCH.
// - Code 77H gives CAN objects 14-15; 70H gives message 1 and control.
// - Codes 7BH, 3DH, 1EH cover event processor channels 0-7.
// - Only direct accesses are windowed; indirect and indexed go straight.
// - Select cleared to zero turns windowing off.
// - Bit 7 is bus hold enable only; bits 6:0 pick the window.
`timescale 1ns/100ps
`include "window_remap_defs.svh"

module register_window_remap
  import window_remap_pkg::*;
#(
  parameter bit HAS_XRAM = 1'b1,
  parameter bit HAS_CAN = 1'b1,
  parameter logic [15:0] UPPER_TOP = `UPPER_TOP_DEFAULT
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_direct,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] mem_addr,
  output logic mem_req,
  output logic mem_we,
  output logic [7:0] mem_wdata,
  output logic [7:0] cpu_rdata,
  output logic cpu_rvalid,
  output logic bus_hold_enable,
  output logic [6:0] window_sel,
  output logic window_active
);
  // ============================================================
  // Window-select register
  logic [7:0] sel_q;
  logic [7:0] sel_d;
  win_size_t size;
  seg_kind_t kind;
  logic [15:0] seg_base;
  logic [15:0] win_base;
  logic [15:0] phys;
  logic in_window;
  logic blocked;
  logic sel_write;

  // The select register itself is reached directly, never through a window
  assign sel_write = cpu_req && cpu_we && cpu_addr == {8'h00, `SEL_ADDR} && !in_window;

  always_comb begin
    sel_d = sel_q;
    if (sel_write) begin
      sel_d = cpu_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sel_q <= `SEL_RESET;
    end else begin
      sel_q <= sel_d;
    end
  end

  // ============================================================
  // Decode and translate
  window_decode #(
    .HAS_XRAM(HAS_XRAM),
    .HAS_CAN(HAS_CAN),
    .UPPER_TOP(UPPER_TOP)
  ) window_decode_i (
    .sel(sel_q[6:0]),
    .size(size),
    .kind(kind),
    .seg_base(seg_base),
    .win_base(win_base)
  );

  // Direct mode only applies to 8-bit addresses; wider ones pass through
  window_translate window_translate_i (
    .direct_addr(cpu_addr[7:0]),
    .direct_mode(cpu_direct && cpu_addr[15:8] == 8'h00),
    .size(size),
    .kind(kind),
    .seg_base(seg_base),
    .win_base(win_base),
    .phys_addr(phys),
    .in_window(in_window),
    .blocked(blocked)
  );

  // ============================================================
  // Memory request stage
  logic [15:0] maddr_q;
  logic [15:0] maddr_d;
  logic mreq_q;
  logic mreq_d;
  logic mwe_q;
  logic mwe_d;
  logic [7:0] mwdata_q;
  logic [7:0] mwdata_d;
  logic rd_pend_q;
  logic rd_pend_d;
  logic rd_block_q;
  logic rd_block_d;

  always_comb begin
    // Translated address only inside the window; wide direct addresses keep their high byte
    maddr_d = in_window ? phys : cpu_addr;
    mwdata_d = cpu_wdata;
    // Blocked accesses issue nothing: writes vanish
    mreq_d = cpu_req && !blocked;
    mwe_d = cpu_req && cpu_we && !blocked;
    rd_pend_d = cpu_req && !cpu_we;
    rd_block_d = cpu_req && !cpu_we && blocked;
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      maddr_q <= 16'h0000;
      mreq_q <= 1'b0;
      mwe_q <= 1'b0;
      mwdata_q <= 8'h00;
      rd_pend_q <= 1'b0;
      rd_block_q <= 1'b0;
    end else begin
      maddr_q <= maddr_d;
      mreq_q <= mreq_d;
      mwe_q <= mwe_d;
      mwdata_q <= mwdata_d;
      rd_pend_q <= rd_pend_d;
      rd_block_q <= rd_block_d;
    end
  end

  // ============================================================
  // Read return stage
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  always_comb begin
    rvalid_d = rd_pend_q;
    rdata_d = rdata_q;
    if (rd_pend_q) begin
      rdata_d = rd_block_q ? `UNMAPPED_READ : mem_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // ============================================================
  // Status outputs
  logic active_q;
  logic active_d;

  // Zero select disables windowing
  assign active_d = sel_d[6:0] != 7'h00;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      active_q <= 1'b0;
    end else begin
      active_q <= active_d;
    end
  end

  assign mem_addr = maddr_q;
  assign mem_req = mreq_q;
  assign mem_we = mwe_q;
  assign mem_wdata = mwdata_q;
  assign cpu_rdata = rdata_q;
  assign cpu_rvalid = rvalid_q;
  assign bus_hold_enable = sel_q[`SEL_HOLD_BIT];
  assign window_sel = sel_q[6:0];
  assign window_active = active_q;
endmodule

// ==== core/window_remap_defs.svh ====
/*
  Constants for the register-window remap logic: window bases, segment
  bases, select-code ranges and the blocked range.
  Assumes inclusion by bare name from core design files.
*/
`ifndef WINDOW_REMAP_DEFS_SVH
`define WINDOW_REMAP_DEFS_SVH

// ============================================================
// Window bases in the lower register file
`define WIN_BASE_32 16'h00e0
`define WIN_BASE_64 16'h00c0
`define WIN_BASE_128 16'h0080

// ============================================================
// Segment bases and first and last select codes
`define SEG_UPPER_BASE 16'h0100
`define SEG_XRAM_BASE 16'h1c00
`define SEG_CAN_BASE 16'h1e00
`define SEG_PERIPH_BASE 16'h1f00
`define SEL32_UPPER_LO 7'h48
`define SEL32_UPPER_HI 7'h5f
`define SEL32_XRAM_LO 7'h60
`define SEL32_XRAM_HI 7'h6f
`define SEL32_CAN_LO 7'h70
`define SEL32_CAN_HI 7'h77
`define SEL32_PERIPH_LO 7'h78
`define SEL32_PERIPH_HI 7'h7f
`define SEL64_UPPER_LO 7'h24
`define SEL64_UPPER_HI 7'h2f
`define SEL64_XRAM_LO 7'h30
`define SEL64_XRAM_HI 7'h37
`define SEL64_CAN_LO 7'h38
`define SEL64_CAN_HI 7'h3b
`define SEL64_PERIPH_LO 7'h3c
`define SEL64_PERIPH_HI 7'h3f
`define SEL128_UPPER_LO 7'h12
`define SEL128_UPPER_HI 7'h17
`define SEL128_XRAM_LO 7'h18
`define SEL128_XRAM_HI 7'h1b
`define SEL128_CAN_LO 7'h1c
`define SEL128_CAN_HI 7'h1d
`define SEL128_PERIPH_LO 7'h1e
`define SEL128_PERIPH_HI 7'h1f

// ============================================================
// Unwindowable physical range and its read value
`define BLOCK_LO 16'h1fe0
`define BLOCK_HI 16'h1fff
`define UNMAPPED_READ 8'hff

// ============================================================
// Window-select register
`define SEL_RESET 8'h00
`define SEL_HOLD_BIT 7
`define SEL_ADDR 8'h14
`define UPPER_TOP_DEFAULT 16'h03ff
`endif

// ==== core/window_remap_pkg.sv ====
/*
  Types for the register-window remap logic.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package window_remap_pkg;
  typedef enum logic [1:0] {
    WSIZE_NONE = 2'b00,
    WSIZE_32 = 2'b01,
    WSIZE_64 = 2'b10,
    WSIZE_128 = 2'b11
  } win_size_t;

  typedef enum logic [2:0] {
    SEG_NONE = 3'b000,
    SEG_UPPER = 3'b001,
    SEG_XRAM = 3'b010,
    SEG_CAN = 3'b011,
    SEG_PERIPH = 3'b100
  } seg_kind_t;
endpackage

// ==== core/window_decode.sv ====
/*
  Decodes the seven-bit window select into size, segment kind and the
  physical base of the selected segment.
  Assumes a registered select value from the same clock domain.
*/
`timescale 1ns/100ps
`include "window_remap_defs.svh"

module window_decode
  import window_remap_pkg::*;
#(
  parameter bit HAS_XRAM = 1'b1,
  parameter bit HAS_CAN = 1'b1,
  parameter logic [15:0] UPPER_TOP = `UPPER_TOP_DEFAULT
) (
  input wire logic [6:0] sel,
  output win_size_t size,
  output seg_kind_t kind,
  output logic [15:0] seg_base,
  output logic [15:0] win_base
);
  logic [15:0] seg_off;

  always_comb begin
    size = WSIZE_NONE;
    kind = SEG_NONE;
    seg_off = 16'h0000;
    seg_base = 16'h0000;
    win_base = 16'h0000;
    // Leading set bit gives size
    if (sel[6]) begin
      size = WSIZE_32;
      win_base = `WIN_BASE_32;
      if (sel >= `SEL32_PERIPH_LO) begin
        kind = SEG_PERIPH;
        seg_off = {6'h00, 5'(sel - `SEL32_PERIPH_LO), 5'h00};
      end else if (sel >= `SEL32_CAN_LO) begin
        kind = SEG_CAN;
        seg_off = {6'h00, 5'(sel - `SEL32_CAN_LO), 5'h00};
      end else if (sel >= `SEL32_XRAM_LO) begin
        kind = SEG_XRAM;
        seg_off = {6'h00, 5'(sel - `SEL32_XRAM_LO), 5'h00};
      end else if (sel >= `SEL32_UPPER_LO) begin
        kind = SEG_UPPER;
        seg_off = {6'h00, 5'(sel - `SEL32_UPPER_LO), 5'h00};
      end
    end else if (sel[5]) begin
      size = WSIZE_64;
      win_base = `WIN_BASE_64;
      if (sel >= `SEL64_PERIPH_LO) begin
        kind = SEG_PERIPH;
        seg_off = {5'h00, 5'(sel - `SEL64_PERIPH_LO), 6'h00};
      end else if (sel >= `SEL64_CAN_LO) begin
        kind = SEG_CAN;
        seg_off = {5'h00, 5'(sel - `SEL64_CAN_LO), 6'h00};
      end else if (sel >= `SEL64_XRAM_LO) begin
        kind = SEG_XRAM;
        seg_off = {5'h00, 5'(sel - `SEL64_XRAM_LO), 6'h00};
      end else if (sel >= `SEL64_UPPER_LO) begin
        kind = SEG_UPPER;
        seg_off = {5'h00, 5'(sel - `SEL64_UPPER_LO), 6'h00};
      end
    end else if (sel[4]) begin
      size = WSIZE_128;
      win_base = `WIN_BASE_128;
      if (sel >= `SEL128_PERIPH_LO) begin
        kind = SEG_PERIPH;
        seg_off = {4'h0, 5'(sel - `SEL128_PERIPH_LO), 7'h00};
      end else if (sel >= `SEL128_CAN_LO) begin
        kind = SEG_CAN;
        seg_off = {4'h0, 5'(sel - `SEL128_CAN_LO), 7'h00};
      end else if (sel >= `SEL128_XRAM_LO) begin
        kind = SEG_XRAM;
        seg_off = {4'h0, 5'(sel - `SEL128_XRAM_LO), 7'h00};
      end else if (sel >= `SEL128_UPPER_LO) begin
        kind = SEG_UPPER;
        seg_off = {4'h0, 5'(sel - `SEL128_UPPER_LO), 7'h00};
      end
    end
    unique case (kind)
      SEG_UPPER: seg_base = `SEG_UPPER_BASE + seg_off;
      SEG_XRAM: seg_base = `SEG_XRAM_BASE + seg_off;
      SEG_CAN: seg_base = `SEG_CAN_BASE + seg_off;
      SEG_PERIPH: seg_base = `SEG_PERIPH_BASE + seg_off;
      default: seg_base = 16'h0000;
    endcase
    // Segments absent on this variant are unmapped
    if ((kind == SEG_XRAM && !HAS_XRAM) || (kind == SEG_CAN && !HAS_CAN)) begin
      kind = SEG_NONE;
    end
    if (kind == SEG_UPPER && seg_base > UPPER_TOP) begin
      kind = SEG_NONE;
    end
  end
endmodule

// ==== core/window_translate.sv ====
/*
  Translates one direct address through the decoded window into a
  physical address with pass, map, blocked and unmapped outcomes.
  Assumes decoder outputs settle within the same cycle.
*/
`timescale 1ns/100ps
`include "window_remap_defs.svh"

module window_translate
  import window_remap_pkg::*;
(
  input wire logic [7:0] direct_addr,
  input wire logic direct_mode,
  input win_size_t size,
  input seg_kind_t kind,
  input wire logic [15:0] seg_base,
  input wire logic [15:0] win_base,
  output logic [15:0] phys_addr,
  output logic in_window,
  output logic blocked
);
  logic [15:0] offset;

  always_comb begin
    offset = 16'h0000;
    phys_addr = {8'h00, direct_addr};
    in_window = 1'b0;
    blocked = 1'b0;
    // Only register-direct accesses are ever windowed
    if (direct_mode && size != WSIZE_NONE && {8'h00, direct_addr} >= win_base) begin
      in_window = 1'b1;
      offset = {8'h00, direct_addr} - win_base;
      phys_addr = seg_base + offset;
      // Top range and unmapped selects read ones, ignore writes
      if (kind == SEG_NONE) begin
        blocked = 1'b1;
      end else if (phys_addr >= `BLOCK_LO) begin
        // Only the top range is cut; 1F80H-1FDFH stay reachable
        blocked = 1'b1;
      end
    end
  end
endmodule

// ==== bench/window_remap_monitor.sv ====
/*
  Port checker for the register window remap block.
  Assumes all segments exist and the upper file reaches 03ffh.
*/
`timescale 1ns/100ps
module window_remap_monitor (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic cpu_direct,
  input wire logic [15:0] cpu_addr,
  input wire logic [7:0] cpu_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [15:0] mem_addr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] cpu_rdata,
  input wire logic cpu_rvalid,
  input wire logic bus_hold_enable,
  input wire logic [6:0] window_sel,
  input wire logic window_active
);
  logic [15:0] p, wbase, base, exp_addr;
  logic hit, sel_wr;
  // ============================================================
  // Reference translation
  always_comb begin
    if (window_sel[6]) begin
      p = {4'h0, window_sel, 5'h00};
      wbase = 16'h00e0;
    end else if (window_sel[5]) begin
      p = {3'h0, window_sel, 6'h00};
      wbase = 16'h00c0;
    end else begin
      p = {2'h0, window_sel, 7'h00};
      wbase = 16'h0080;
    end
    // Upper file sits below the scaled code, the rest above it
    base = (p < 16'h0c00) ? p - 16'h0800 : p + 16'h1000;
    // Codes scaling below 0900H select no segment at all
    hit = (p >= 16'h0900) && (cpu_addr[15:8] == 8'h00) && (cpu_addr >= wbase);
    exp_addr = base + (cpu_addr - wbase);
    sel_wr = cpu_req && cpu_we && (cpu_addr == 16'h0014);
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_read_answer: assert property (cpu_req && !cpu_we |-> ##2 cpu_rvalid)
    else $error("read not answered in two cycles");
  a_rdata_source: assert property (cpu_rvalid |-> cpu_rdata == ($past(mem_req) ? $past(mem_rdata) : 8'hff))
    else $error("read data wrong");
  a_window_map: assert property (cpu_req && cpu_direct && hit && exp_addr < 16'h1fe0
    |=> mem_req && mem_addr == $past(exp_addr))
    else $error("window translation wrong");
  a_top_blocked: assert property (cpu_req && cpu_direct && hit && exp_addr >= 16'h1fe0 |=> !mem_req && !mem_we)
    else $error("blocked range reached memory");
  a_unmapped_drop: assert property (cpu_req && cpu_direct && cpu_addr[15:8] == 8'h00 && cpu_addr >= wbase
    && window_sel[6:4] != 3'h0 && p < 16'h0900 |=> !mem_req && !mem_we)
    else $error("unmapped window reached memory");
  a_indirect_pass: assert property (cpu_req && !cpu_direct |=> mem_req && mem_addr == $past(cpu_addr))
    else $error("indirect access translated");
  a_cleared_pass: assert property (cpu_req && cpu_direct && !window_active && cpu_addr[15:8] == 8'h00
    |=> mem_req && mem_addr == $past(cpu_addr))
    else $error("direct access moved with window off");
  a_select_load: assert property (sel_wr |=> {bus_hold_enable, window_sel} == $past(cpu_wdata)
    && window_active == ($past(cpu_wdata[6:0]) != 7'h00))
    else $error("select register load wrong");
  a_select_holds: assert property (!sel_wr |=> $stable(window_sel))
    else $error("select changed without write");
  a_write_pass: assert property (cpu_req && cpu_we && !cpu_direct |=> mem_we && mem_wdata == $past(cpu_wdata))
    else $error("write not passed on");
  c_blocked: cover property (cpu_req && cpu_direct && hit && exp_addr >= 16'h1fe0);
  c_mapped: cover property (cpu_req && cpu_direct && hit && window_sel == 7'h4a);
  c_sel_hold: cover property (sel_wr && cpu_wdata[7]);
endmodule

bind register_window_remap window_remap_monitor window_remap_monitor_i (.clk(clk), .reset_n(reset_n),
  .cpu_req(cpu_req), .cpu_we(cpu_we), .cpu_direct(cpu_direct), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
  .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_wdata(mem_wdata),
  .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .bus_hold_enable(bus_hold_enable),
  .window_sel(window_sel), .window_active(window_active));

// ==== bench/window_memory_model.sv ====
/*
  Byte memory standing behind the remap block.
  Assumes reads are answered combinationally in the mem_req cycle.
*/
`timescale 1ns/100ps
module window_memory_model (
  input wire logic clk,
  input wire logic [15:0] mem_addr,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [8192];
  logic [7:0] last_q = 8'h00;
  // ============================================================
  // Storage
  initial begin
    for (int i = 0; i < 8192; i++) begin
      ram[i] = 8'(i) ^ 8'(i >> 8);
    end
  end
  // Idle bus shows the inverse of the last value, never a stale copy
  assign mem_rdata = (mem_req && !mem_we) ? ram[mem_addr[12:0]] : ~last_q;
  always @(posedge clk) begin
    last_q <= mem_rdata;
    if (mem_req && mem_we) begin
      ram[mem_addr[12:0]] <= mem_wdata;
    end
  end
endmodule

// ==== bench/register_window_remap_test.sv ====
/*
  Self-checking bench for the register window remap block.
  Assumes the memory model and the bound port checker.
*/
`timescale 1ns/100ps
module register_window_remap_test;
  logic clk = 1'b0, reset_n = 1'b0, cpu_req = 1'b0, cpu_we = 1'b0, cpu_direct = 1'b0;
  logic [15:0] cpu_addr = 16'h0000, mem_addr, s_addr;
  logic [7:0] cpu_wdata = 8'h00, mem_rdata, cpu_rdata, mem_wdata, s_rd;
  logic mem_req, mem_we, cpu_rvalid, bus_hold_enable, window_active, s_req, s_we, s_rv;
  logic [6:0] window_sel;
  int error_cnt = 0, checks = 0, cycles = 0;
  logic [39:0] tbl [16] = '{40'h3e00cc1f8c, 40'h1f00821f82, 40'h7700e01ee0, 40'h7000ff1e1f,
    40'h7b00e51f65, 40'h3d00c01f40, 40'h1e00ff1f7f, 40'h5f00ff03ff, 40'h2400c10101, 40'h1200800100,
    40'h6000e31c03, 40'h3000c01c00, 40'h1b00801d80, 40'h7800e01f00, 40'h3c00c51f05, 40'h1c00801e00};
  always #50 clk = ~clk;
  register_window_remap register_window_remap_i (.clk(clk), .reset_n(reset_n), .cpu_req(cpu_req),
    .cpu_we(cpu_we), .cpu_direct(cpu_direct), .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata),
    .mem_rdata(mem_rdata), .mem_addr(mem_addr), .mem_req(mem_req), .mem_we(mem_we), .mem_wdata(mem_wdata),
    .cpu_rdata(cpu_rdata), .cpu_rvalid(cpu_rvalid), .bus_hold_enable(bus_hold_enable),
    .window_sel(window_sel), .window_active(window_active));
  window_memory_model window_memory_model_i (.clk(clk), .mem_addr(mem_addr), .mem_req(mem_req),
    .mem_we(mem_we), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));
  // ============================================================
  // Helpers
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ {3'b000, a[12:8]};
  endfunction
  task automatic chk(input logic [15:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic we, dir, input logic [15:0] a, input logic [7:0] wd);
    @(negedge clk);
    cpu_req = 1'b1;
    cpu_we = we;
    cpu_direct = dir;
    cpu_addr = a;
    cpu_wdata = wd;
    @(negedge clk);
    cpu_req = 1'b0;
    s_addr = mem_addr;
    s_req = mem_req;
    s_we = mem_we;
    @(negedge clk);
    s_rv = cpu_rvalid;
    s_rd = cpu_rdata;
  endtask
  task automatic look(input logic dir, input logic [15:0] a, phys, input logic [7:0] data, input logic ok);
    acc(1'b0, dir, a, 8'h00);
    chk({15'h0, s_req}, {15'h0, ok});
    if (ok) chk(s_addr, phys);
    chk({15'h0, s_rv}, 16'h0001);
    chk({8'h00, s_rd}, ok ? {8'h00, data} : 16'h00ff);
  endtask
  // ============================================================
  // Scenarios
  task automatic t_reset();
    chk({8'h00, bus_hold_enable, window_sel}, 16'h0000);
    look(1'b1, 16'h00eb, 16'h00eb, pat(16'h00eb), 1'b1);
  endtask
  task automatic t_select();
    acc(1'b1, 1'b1, 16'h0014, 8'hca);
    chk({8'h00, bus_hold_enable, window_sel}, 16'h00ca);
    chk({15'h0, window_active}, 16'h0001);
    look(1'b1, 16'h00eb, 16'h014b, pat(16'h014b), 1'b1);
    look(1'b0, 16'h00eb, 16'h00eb, pat(16'h00eb), 1'b1);
    look(1'b1, 16'h00df, 16'h00df, pat(16'h00df), 1'b1);
    acc(1'b1, 1'b1, 16'h00e1, 8'h5a);
    look(1'b0, 16'h0141, 16'h0141, 8'h5a, 1'b1);
  endtask
  task automatic t_table();
    foreach (tbl[i]) begin
      acc(1'b1, 1'b1, 16'h0014, tbl[i][39:32]);
      look(1'b1, tbl[i][31:16], tbl[i][15:0], pat(tbl[i][15:0]), 1'b1);
    end
  endtask
  task automatic t_blocked();
    acc(1'b1, 1'b1, 16'h0014, 8'h7f);
    look(1'b1, 16'h00e0, 16'h0000, 8'hff, 1'b0);
    acc(1'b1, 1'b1, 16'h00e5, 8'h33);
    chk({14'h0, s_req, s_we}, 16'h0000);
    look(1'b0, 16'h1fe5, 16'h1fe5, pat(16'h1fe5), 1'b1);
    acc(1'b1, 1'b1, 16'h0014, 8'h1f);
    look(1'b1, 16'h00ff, 16'h0000, 8'hff, 1'b0);
    look(1'b1, 16'h00df, 16'h1fdf, pat(16'h1fdf), 1'b1);
    look(1'b0, 16'h1ff1, 16'h1ff1, pat(16'h1ff1), 1'b1);
    look(1'b1, 16'h1ff1, 16'h1ff1, pat(16'h1ff1), 1'b1);
    acc(1'b1, 1'b1, 16'h0014, 8'h45);
    look(1'b1, 16'h00f0, 16'h0000, 8'hff, 1'b0);
    acc(1'b1, 1'b1, 16'h0014, 8'h21);
    look(1'b1, 16'h00c3, 16'h0000, 8'hff, 1'b0);
  endtask
  task automatic t_clear();
    acc(1'b1, 1'b1, 16'h0014, 8'h05);
    look(1'b1, 16'h00e0, 16'h00e0, pat(16'h00e0), 1'b1);
    acc(1'b1, 1'b1, 16'h0014, 8'h00);
    chk({15'h0, window_active}, 16'h0000);
    look(1'b1, 16'h00e0, 16'h00e0, pat(16'h00e0), 1'b1);
  endtask
  // ============================================================
  // Run control
  task automatic stop_test();
    if (error_cnt == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      error_cnt++;
      stop_test();
    end
  end
  initial begin
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    t_reset();
    t_select();
    t_table();
    t_blocked();
    t_clear();
    stop_test();
  end
endmodule
